// *** fpu_exc_pkg.sv ***
// Package of constants, types and carriers for the floating-point exception unit.
package fpu_exc_pkg;

   // ****************************************************************
   // Register byte offsets on the AHB-Lite bus
   // ****************************************************************
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_SYSCTL = 8'h08;
   localparam logic [7:0] OFS_FAULT_SEL = 8'h0C;
   localparam logic [7:0] OFS_FAULT_IP = 8'h10;
   localparam logic [7:0] OFS_CAUSE = 8'h14;

   // ****************************************************************
   // Status word fields
   // ****************************************************************
   localparam int BIT_INVALID = 0;
   localparam int BIT_DENORM = 1;
   localparam int BIT_ZDIV = 2;
   localparam int BIT_OVF = 3;
   localparam int BIT_UNF = 4;
   localparam int BIT_PREC = 5;
   localparam int BIT_STACK = 6;
   localparam int BIT_SUMMARY = 7;
   localparam int BIT_C1 = 9;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] STATUS_WMASK = 16'h02FF;

   // ****************************************************************
   // Control word fields: masks in bits 5..0, precision, rounding, defer
   // ****************************************************************
   localparam int CTL_PC_LO = 8;
   localparam int CTL_RC_LO = 10;
   localparam int CTL_DEFER = 15;
   localparam logic [15:0] CONTROL_RST = 16'h037F;
   localparam logic [15:0] CONTROL_WMASK = 16'h8F3F;

   // ****************************************************************
   // System control register fields
   // ****************************************************************
   localparam int SYS_EM = 2;
   localparam int SYS_TS = 3;
   localparam int SYS_NE = 5;
   localparam logic [31:0] SYSCTL_RST = 32'h0000_0000;
   localparam logic [31:0] SYSCTL_WMASK = 32'h0000_002C;

   // ****************************************************************
   // Vectors, precisions and rounding codes
   // ****************************************************************
   localparam logic [7:0] VEC_UD = 8'h06;
   localparam logic [7:0] VEC_NM = 8'h07;
   localparam logic [7:0] VEC_MF = 8'h10;
   localparam logic [1:0] PREC_EXT = 2'h3;
   localparam logic [1:0] RC_CHOP = 2'h3;
   localparam logic [14:0] EXP_ONES = 15'h7FFF;

   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [2:0] {
      CLS_ZERO = 3'b000,
      CLS_DENORMAL = 3'b001,
      CLS_NORMAL = 3'b010,
      CLS_INF = 3'b011,
      CLS_QNAN = 3'b100,
      CLS_SNAN = 3'b101,
      CLS_UNSUPPORTED = 3'b110
   } operand_class_t;

   typedef enum logic [3:0] {
      OP_ARITH = 4'h0,
      OP_COMPARE = 4'h1,
      OP_STORE_INT = 4'h2,
      OP_STORE_BCD = 4'h3,
      OP_SQRT = 4'h4,
      OP_DIV = 4'h5,
      OP_PREM = 4'h6,
      OP_TRANS = 4'h7,
      OP_EXTRACT = 4'h8,
      OP_LOAD = 4'h9
   } op_class_t;

   typedef enum logic [2:0] {
      RES_NORMAL = 3'b000,
      RES_QNAN = 3'b001,
      RES_INDEFINITE = 3'b010,
      RES_MAX_FINITE = 3'b011,
      RES_INF = 3'b100,
      RES_ADJUSTED = 3'b101
   } result_sel_t;

   typedef enum logic [2:0] {
      CAUSE_NONE = 3'b000,
      CAUSE_INVALID = 3'b001,
      CAUSE_DENORM = 3'b010,
      CAUSE_ZDIV = 3'b011,
      CAUSE_OVF = 3'b100,
      CAUSE_UNF = 3'b101,
      CAUSE_PREC = 3'b110
   } cause_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DATA = 2'b01
   } bus_state_t;

   // ****************************************************************
   // Carriers between the integer core and the unit
   // ****************************************************************
   typedef struct packed {
      logic valid;
      logic defined;
      op_class_t op;
      logic use_b;
      logic uses_pc;
      logic fixed_prec_en;
      logic [1:0] fixed_prec;
      logic to_stack;
      logic [15:0] prefix_sel;
      logic [31:0] prefix_ip;
      logic [1:0][79:0] opnd;
      logic zero_divide;
      logic res_overflow;
      logic res_tiny;
      logic res_loss;
      logic res_inexact;
      logic stack_over;
      logic stack_under;
   } fp_req_t;

   typedef struct packed {
      logic done;
      logic retry;
      logic vec_valid;
      logic [7:0] vec_num;
      result_sel_t result;
      logic [1:0] round_prec;
      logic [1:0] normalize;
   } fp_resp_t;

endpackage

// *** operand_classifier.sv ***
// Classifier of one 80-bit extended-precision operand encoding.
`timescale 1ns/1ns
module operand_classifier
   import fpu_exc_pkg::*;
(
   // Operand in
   input wire logic [79:0] value,
   // Class out
   output operand_class_t cls
);

   logic [14:0] expo;
   logic int_bit;
   logic [62:0] frac;

   // Split the encoding into exponent, explicit integer bit and fraction.
   assign expo = value[78:64];
   assign int_bit = value[63];
   assign frac = value[62:0];

   // Encodings with a clear integer bit and a nonzero exponent are unsupported.
   always_comb
   begin
      if (expo == 15'h0000)
      begin
         cls = ({int_bit, frac} == 64'h0000_0000_0000_0000) ? CLS_ZERO : CLS_DENORMAL;
      end
      else if (!int_bit)
      begin
         cls = CLS_UNSUPPORTED;
      end
      else if (expo == EXP_ONES)
      begin
         if (frac == 63'h0000_0000_0000_0000)
            cls = CLS_INF;
         else
            cls = frac[62] ? CLS_QNAN : CLS_SNAN;
      end
      else
      begin
         cls = CLS_NORMAL;
      end
   end

endmodule

// *** fpu_exception_detection.sv ***
// Exception detection, flag keeping and reporting for the floating-point unit.
// Notes on behaviour
// - Signaling and quiet NaNs are told apart; generated NaNs are quiet, quiet ones pass.
// - Signaling NaN raises invalid; compare and integer or BCD stores also on quiet NaN.
// - Unsupported encodings are never produced and raise invalid in arithmetic.
// - With denormal masked, denormal operands are normalized before use.
// - Transcendental and exponent extraction raise denormal on denormal operands.
// - Masked overflow under chop rounding yields the largest finite value of that sign.
// - Unmasked overflow also sets the precision flag.
// - Unmasked stack overflow result rounds by precision field or opcode precision.
// - Masked underflow is flagged only when tiny and accuracy is lost.
// - Unmasked stack underflow adjusts exponent then rounds by field or extended.
// - Denormal holds the same priority whether masked or not.
// - Fault address saved is the first prefix byte of the instruction.
// - Undefined opcode raises vector 6.
// - Any opcode raises vector 7 while task switched or emulate is set.
// - Undefined opcode does not check or report pending errors.
// - Unmasked exception raises error output at completion, or deferred to next.
// - With an exception pending, the next instruction does not execute.
// - Root, divide, remainder and conversions normalize denormals without invalid.
// - Error select bit routes errors to vector 16 or the pin; resets clear.
// - Stack fault sets invalid and stack fault, C1 shows overflow versus underflow.
`timescale 1ns/1ns
module fpu_exception_detection
   import fpu_exc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Instruction dispatch from the integer core
   input wire fp_req_t req,
   output fp_resp_t resp,
   // External error output
   output logic fp_error_out
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   bus_state_t bus_state_reg, bus_state_next;
   logic [7:0] addr_reg, addr_next;
   logic wr_reg, wr_next;
   logic hreadyout_reg, hreadyout_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic [15:0] status_reg, status_next;
   logic [15:0] control_reg, control_next;
   logic [31:0] sysctl_reg, sysctl_next;
   logic [15:0] fault_sel_reg, fault_sel_next;
   logic [31:0] fault_ip_reg, fault_ip_next;
   cause_t cause_reg, cause_next;
   fp_resp_t resp_reg, resp_next;
   logic fp_error_out_reg, fp_error_out_next;
   operand_class_t opnd_cls [2];
   logic bus_wr, status_wr, tsem, pending, exec_go, unmasked, norm_op;
   logic any_snan, any_qnan, any_unsup, any_denorm;
   logic inv, den, zd, ovf, unf, prec;
   logic [5:0] hw_set, masks;
   logic [1:0] rc, prec_sel;

   // ****************************************************************
   // Operand classification
   // ****************************************************************
   // One classifier per source operand.
   for (genvar g = 0; g < 2; g++)
   begin : g_cls
      operand_classifier u_cls (
         .value(req.opnd[g]),
         .cls(opnd_cls[g])
      );
   end

   // ****************************************************************
   // Exception detection
   // ****************************************************************
   // Common terms of the dispatch decision.
   assign masks = control_reg[5:0];
   assign rc = control_reg[CTL_RC_LO +: 2];
   assign tsem = sysctl_reg[SYS_TS] | sysctl_reg[SYS_EM];
   assign pending = status_reg[BIT_SUMMARY];
   assign exec_go = req.valid & req.defined & !tsem & !pending;
   assign bus_wr = (bus_state_reg == BUS_DATA) & wr_reg;
   assign status_wr = bus_wr & (addr_reg == OFS_STATUS);

   // Raise the exception terms of an executing instruction.
   always_comb
   begin
      any_snan = 1'b0;
      any_qnan = 1'b0;
      any_unsup = 1'b0;
      any_denorm = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         if ((i == 0) || req.use_b)
         begin
            any_snan = any_snan | (opnd_cls[i] == CLS_SNAN);
            any_qnan = any_qnan | (opnd_cls[i] == CLS_QNAN);
            any_unsup = any_unsup | (opnd_cls[i] == CLS_UNSUPPORTED);
            any_denorm = any_denorm | (opnd_cls[i] == CLS_DENORMAL);
         end
      end
      // Quiet NaNs fault only for compare and the integer and BCD stores.
      inv = any_snan | (any_qnan & ((req.op == OP_COMPARE) | (req.op == OP_STORE_INT)
            | (req.op == OP_STORE_BCD)));
      inv = inv | (any_unsup & (req.op != OP_LOAD));
      inv = inv | req.stack_over | req.stack_under;
      // A denormal never feeds the invalid term, only its own flag.
      den = any_denorm & (req.op != OP_LOAD) & !inv;
      zd = req.zero_divide & !inv;
      ovf = req.res_overflow & !inv;
      unf = req.res_tiny & !inv & (masks[BIT_UNF] ? req.res_loss : 1'b1);
      prec = (req.res_inexact | ovf) & !inv;
      hw_set = exec_go ? {prec, unf, ovf, zd, den, inv} : 6'h00;
      unmasked = |(hw_set & ~masks);
      norm_op = (req.op == OP_SQRT) | (req.op == OP_DIV) | (req.op == OP_PREM)
            | (req.op == OP_STORE_INT) | (req.op == OP_STORE_BCD);
      prec_sel = req.fixed_prec_en ? req.fixed_prec
            : (req.uses_pc ? control_reg[CTL_PC_LO +: 2] : PREC_EXT);
   end

   // ****************************************************************
   // Dispatch answer, flags and error output
   // ****************************************************************
   // Decide the answer to a dispatched instruction and update the flags.
   always_comb
   begin
      resp_next = '0;
      resp_next.round_prec = PREC_EXT;
      cause_next = cause_reg;
      fault_sel_next = fault_sel_reg;
      fault_ip_next = fault_ip_reg;
      fp_error_out_next = fp_error_out_reg;
      status_next = status_wr ? (hwdata[15:0] & STATUS_WMASK) : status_reg;
      if (req.valid && tsem)
      begin
         resp_next.vec_valid = 1'b1;
         resp_next.vec_num = VEC_NM;
      end
      else if (req.valid && !req.defined)
      begin
         resp_next.vec_valid = 1'b1;
         resp_next.vec_num = VEC_UD;
      end
      else if (req.valid && pending)
      begin
         // The blocked instruction is reported, not executed.
         resp_next.retry = 1'b1;
         if (sysctl_reg[SYS_NE])
         begin
            resp_next.vec_valid = 1'b1;
            resp_next.vec_num = VEC_MF;
         end
         else
            fp_error_out_next = 1'b1;
      end
      else if (exec_go)
      begin
         resp_next.done = 1'b1;
         resp_next.round_prec = prec_sel;
         for (int i = 0; i < 2; i++)
         begin
            resp_next.normalize[i] = ((i == 0) || req.use_b) && (opnd_cls[i] == CLS_DENORMAL)
                  && (masks[BIT_DENORM] || norm_op);
         end
         if (inv)
            resp_next.result = (any_snan | any_qnan) & !any_unsup ? RES_QNAN : RES_INDEFINITE;
         else if (ovf && masks[BIT_OVF])
            resp_next.result = (rc == RC_CHOP) ? RES_MAX_FINITE : RES_INF;
         else if ((ovf && !masks[BIT_OVF]) || (unf && !masks[BIT_UNF]))
            resp_next.result = req.to_stack ? RES_ADJUSTED : RES_NORMAL;
         else
            resp_next.result = RES_NORMAL;
         // Fixed order: denormal sits second whatever its mask.
         if (inv)
            cause_next = CAUSE_INVALID;
         else if (den)
            cause_next = CAUSE_DENORM;
         else if (zd)
            cause_next = CAUSE_ZDIV;
         else if (ovf)
            cause_next = CAUSE_OVF;
         else if (unf)
            cause_next = CAUSE_UNF;
         else if (prec)
            cause_next = CAUSE_PREC;
         if (unmasked)
         begin
            status_next[BIT_SUMMARY] = 1'b1;
            fault_sel_next = req.prefix_sel;
            fault_ip_next = req.prefix_ip;
            fp_error_out_next = !sysctl_reg[SYS_NE] && !control_reg[CTL_DEFER];
         end
         if (req.stack_over || req.stack_under)
         begin
            status_next[BIT_STACK] = 1'b1;
            status_next[BIT_C1] = req.stack_over;
         end
      end
      // Hardware sets win over a software clear in the same cycle.
      status_next[5:0] = status_next[5:0] | hw_set;
      if (!status_next[BIT_SUMMARY])
         fp_error_out_next = 1'b0;
   end

   // Register the dispatch answer, flags and error output.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         resp_reg <= '0;
         cause_reg <= CAUSE_NONE;
         fault_sel_reg <= 16'h0000;
         fault_ip_reg <= 32'h0000_0000;
         fp_error_out_reg <= 1'b0;
         status_reg <= STATUS_RST;
      end
      else
      begin
         resp_reg <= resp_next;
         cause_reg <= cause_next;
         fault_sel_reg <= fault_sel_next;
         fault_ip_reg <= fault_ip_next;
         fp_error_out_reg <= fp_error_out_next;
         status_reg <= status_next;
      end
   end

   // ****************************************************************
   // AHB-Lite register slave
   // ****************************************************************
   // Each transfer takes one wait state, then read data stands from a flop.
   always_comb
   begin
      bus_state_next = bus_state_reg;
      addr_next = addr_reg;
      wr_next = wr_reg;
      hreadyout_next = hreadyout_reg;
      hrdata_next = hrdata_reg;
      control_next = control_reg;
      sysctl_next = sysctl_reg;
      unique case (bus_state_reg)
         BUS_IDLE:
         begin
            hreadyout_next = 1'b1;
            if (hsel && hready && htrans[1])
            begin
               addr_next = haddr[7:0];
               wr_next = hwrite;
               hreadyout_next = 1'b0;
               bus_state_next = BUS_DATA;
            end
         end
         BUS_DATA:
         begin
            hreadyout_next = 1'b1;
            bus_state_next = BUS_IDLE;
            if (wr_reg && (addr_reg == OFS_CONTROL))
               control_next = hwdata[15:0] & CONTROL_WMASK;
            if (wr_reg && (addr_reg == OFS_SYSCTL))
               sysctl_next = hwdata & SYSCTL_WMASK;
            unique case (addr_reg)
               OFS_STATUS: hrdata_next = {16'h0000, status_reg};
               OFS_CONTROL: hrdata_next = {16'h0000, control_reg};
               OFS_SYSCTL: hrdata_next = sysctl_reg;
               OFS_FAULT_SEL: hrdata_next = {16'h0000, fault_sel_reg};
               OFS_FAULT_IP: hrdata_next = fault_ip_reg;
               OFS_CAUSE: hrdata_next = {29'h0000_0000, cause_reg};
               default: hrdata_next = 32'h0000_0000;
            endcase
         end
         default: bus_state_next = BUS_IDLE;
      endcase
   end

   // Register the bus state and the control and system control registers.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         bus_state_reg <= BUS_IDLE;
         addr_reg <= 8'h00;
         wr_reg <= 1'b0;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= 32'h0000_0000;
         control_reg <= CONTROL_RST;
         sysctl_reg <= SYSCTL_RST;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         addr_reg <= addr_next;
         wr_reg <= wr_next;
         hreadyout_reg <= hreadyout_next;
         hrdata_reg <= hrdata_next;
         control_reg <= control_next;
         sysctl_reg <= sysctl_next;
      end
   end

   // Outputs straight from flops; hresp is tied low.
   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;
   assign hresp = 1'b0;
   assign resp = resp_reg;
   assign fp_error_out = fp_error_out_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   snan_invalid_a: assert property (exec_go && any_snan |=> status_reg[BIT_INVALID])
      else $error("Signaling NaN did not set the invalid flag.");
   unsup_invalid_a: assert property (exec_go && any_unsup && req.op != OP_LOAD
         |=> status_reg[BIT_INVALID] && resp_reg.result != RES_QNAN)
      else $error("Unsupported encoding not flagged invalid.");
   chop_max_a: assert property (exec_go && ovf && masks[BIT_OVF] && rc == RC_CHOP
         |=> resp_reg.result == RES_MAX_FINITE)
      else $error("Masked chop overflow did not give the largest finite value.");
   ovf_prec_a: assert property (exec_go && ovf && !masks[BIT_OVF]
         |=> status_reg[BIT_PREC] && status_reg[BIT_OVF])
      else $error("Unmasked overflow did not set precision.");
   denorm_prio_a: assert property (exec_go && den |=> cause_reg == CAUSE_DENORM)
      else $error("Denormal cause lost its fixed place.");
   ud_vector_a: assert property (req.valid && !tsem && !req.defined
         |=> resp_reg.vec_valid && resp_reg.vec_num == VEC_UD && !resp_reg.done)
      else $error("Undefined opcode did not raise vector 6.");
   ud_no_check_a: assert property (req.valid && !tsem && !req.defined && !bus_wr
         |=> $stable(status_reg) && $stable(fp_error_out))
      else $error("Undefined opcode disturbed the error state.");
   nm_vector_a: assert property (req.valid && tsem
         |=> resp_reg.vec_valid && resp_reg.vec_num == VEC_NM)
      else $error("Task switched or emulate did not raise vector 7.");
   blocked_a: assert property (req.valid && req.defined && !tsem && pending
         |=> !resp_reg.done && resp_reg.retry)
      else $error("Instruction executed while an exception was pending.");
   fp_error_out_pin_a: assert property (exec_go && unmasked && !sysctl_reg[SYS_NE]
         && !control_reg[CTL_DEFER] && !status_wr
         |=> fp_error_out ##1 (fp_error_out || !status_reg[BIT_SUMMARY]))
      else $error("Error output not raised at completion.");
   ne_route_a: assert property (req.valid && req.defined && !tsem && pending
         && sysctl_reg[SYS_NE] |=> resp_reg.vec_num == VEC_MF && !fp_error_out)
      else $error("Internal routing did not use vector 16.");
   stack_fault_a: assert property (exec_go && req.stack_over && !req.stack_under
         |=> status_reg[BIT_STACK] && status_reg[BIT_C1] && status_reg[BIT_INVALID])
      else $error("Stack overflow flags wrong.");
   sticky_a: assert property (!status_wr
         |=> (status_reg[5:0] & $past(status_reg[5:0])) == $past(status_reg[5:0]))
      else $error("Exception flag dropped without a clear.");
   fault_addr_a: assert property (exec_go && unmasked
         |=> fault_ip_reg == $past(req.prefix_ip))
      else $error("Fault address not the prefix address.");

endmodule

// *** fpu_irq_model.sv ***
// Model of the outside interrupt controller fed by the error output.
`timescale 1ns/1ns
module fpu_irq_model
(
   // Clock, reset, error in, request out
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fp_error_out,
   output logic maskable_irq_in
);
   // The request follows the error level one cycle later.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         maskable_irq_in <= 1'b0;
      else
         maskable_irq_in <= fp_error_out;
   end
endmodule

// *** test_fpu_exception_detection.sv ***
// Self-checking testbench of the floating-point exception unit.
`timescale 1ns/1ns
module test_fpu_exception_detection import fpu_exc_pkg::*;;
   localparam logic [79:0] ONE = 80'h3FFF_8000_0000_0000_0000;
   localparam logic [79:0] QNAN = 80'h7FFF_C000_0000_0000_0000;
   localparam logic [79:0] SNAN = 80'h7FFF_A000_0000_0000_0000;
   localparam logic [79:0] DEN = 80'h0000_4000_0000_0000_0000;
   localparam logic [79:0] UNS = 80'h3FFF_4000_0000_0000_0000;
   logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, q;
   logic hreadyout, hresp, fp_error_out, irq;
   logic [31:0] hrdata;
   fp_req_t req = '0;
   fp_resp_t resp;
   int n_mismatch = 0, num_checks = 0;
   // The single slave's ready is the bus ready.
   fpu_exception_detection u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .req(req), .resp(resp),
      .fp_error_out(fp_error_out));
   fpu_irq_model u_irq (.ref_clk(ref_clk), .rst(rst), .fp_error_out(fp_error_out),
      .maskable_irq_in(irq));
   // Free-running clock.
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   task complete_run;
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   // Waits for a rising edge with ready high, bounded.
   task wait_ready;
      int i;
      i = 0;
      do
      begin
         @(posedge ref_clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1)
      begin
         n_mismatch++;
         complete_run;
      end
   endtask
   // One single word transfer; read data lands in q.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      q = hrdata;
   endtask
   function automatic fp_req_t mk(input op_class_t op, input logic [79:0] a);
      fp_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.defined = 1'b1;
      r.op = op;
      r.opnd = {ONE, a};
      return r;
   endfunction
   // Issues one request; the answer stands in the cycle after.
   task send(input fp_req_t r);
      @(posedge ref_clk);
      req <= r;
      @(posedge ref_clk);
      req <= '0;
      #1;
   endtask
   task t_reset;
      bus(0, OFS_SYSCTL, 0);
      chk(q, 32'h0);
      chk(hresp, 1'b0);
      bus(0, OFS_CONTROL, 0);
      chk(q, 32'h0000_037F);
      bus(0, 8'h40, 0);
      chk(q, 32'h0);
   endtask
   task t_nan;
      send(mk(OP_ARITH, QNAN));
      bus(0, OFS_STATUS, 0);
      chk(q, 32'h0);
      send(mk(OP_COMPARE, QNAN));
      chk(resp.result, RES_QNAN);
      send(mk(OP_ARITH, ONE));
      bus(0, OFS_STATUS, 0);
      chk(q, 32'h1);
      bus(1, OFS_STATUS, 0);
   endtask
   task t_chop;
      fp_req_t r;
      bus(1, OFS_CONTROL, 32'h0000_0F7F);
      r = mk(OP_ARITH, ONE);
      r.res_overflow = 1'b1;
      send(r);
      chk(resp.result, RES_MAX_FINITE);
      bus(1, OFS_STATUS, 0);
      bus(1, OFS_CONTROL, 32'h0000_037E);
   endtask
   // Denormal, underflow, unmasked overflow, internal routing and stack fault.
   task t_ops;
      fp_req_t r;
      send(mk(OP_TRANS, DEN));
      chk(resp.normalize, 2'b01);
      send(mk(OP_SQRT, DEN));
      chk(resp.done, 1'b1);
      r = mk(OP_ARITH, ONE);
      r.res_tiny = 1'b1;
      send(r);
      bus(0, OFS_STATUS, 0);
      chk(q, 32'h2);
      bus(0, OFS_CAUSE, 0);
      chk(q, CAUSE_DENORM);
      bus(1, OFS_SYSCTL, 32'h20);
      bus(1, OFS_CONTROL, 32'h0000_0236);
      r.res_tiny = 1'b0;
      r.res_overflow = 1'b1;
      r.to_stack = 1'b1;
      r.uses_pc = 1'b1;
      send(r);
      chk(resp.result, RES_ADJUSTED);
      chk(resp.round_prec, 2'h2);
      send(mk(OP_ARITH, ONE));
      chk(resp.vec_num, VEC_MF);
      chk(fp_error_out, 1'b0);
      bus(0, OFS_STATUS, 0);
      chk(q, 32'hAA);
      bus(1, OFS_STATUS, 0);
      r = mk(OP_ARITH, UNS);
      r.stack_over = 1'b1;
      send(r);
      chk(resp.result, RES_INDEFINITE);
      bus(0, OFS_STATUS, 0);
      chk(q, 32'h2C1);
      bus(1, OFS_STATUS, 0);
      bus(1, OFS_SYSCTL, 0);
   endtask
   // Unmasked invalid: error output, blocking, vectors and fault address.
   task t_pending;
      fp_req_t r;
      r = mk(OP_ARITH, SNAN);
      r.prefix_sel = 16'h1234;
      r.prefix_ip = 32'h0000_5678;
      send(r);
      chk(fp_error_out, 1'b1);
      send(mk(OP_ARITH, ONE));
      chk(resp.retry, 1'b1);
      chk(irq, 1'b1);
      r.defined = 1'b0;
      send(r);
      chk(resp.vec_num, VEC_UD);
      bus(0, OFS_STATUS, 0);
      chk(q, 32'h81);
      bus(0, OFS_FAULT_IP, 0);
      chk(q, 32'h5678);
      bus(1, OFS_STATUS, 0);
      @(posedge ref_clk);
      #1;
      chk(fp_error_out, 1'b0);
      bus(1, OFS_SYSCTL, 32'h8);
      send(mk(OP_ARITH, ONE));
      chk(resp.vec_num, VEC_NM);
   endtask
   // Main sequence.
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_nan;
      t_chop;
      t_ops;
      t_pending;
      complete_run;
   end
endmodule
